//--- hw/pwsl_defs.svh
/*
 * constants of the pulse width serial loader: setting width, field split,
 * reset values and timing counts.
 * assumes the includer runs on a 20 MHz core clock.
 */
`ifndef PWSL_DEFS_SVH
`define PWSL_DEFS_SVH

`define PWSL_SET_W 22
`define PWSL_FINE_W 6
`define PWSL_COARSE_W 16
`define PWSL_SET_RST 22'h000000
`define PWSL_CLK_NS 50
// high-z release after enable low, longest time, rounded down, at least one cycle
`define PWSL_TEX_NS 20
`define PWSL_TEX_CYC ((`PWSL_TEX_NS / `PWSL_CLK_NS) < 1 ? 1 : (`PWSL_TEX_NS / `PWSL_CLK_NS))
// fine cell step in fine counts per core cycle
`define PWSL_FINE_STEP 1

`endif

//--- hw/pwsl_pkg.sv
/*
 * types of the pulse width serial loader.
 * assumes pwsl_defs.svh is on the include path.
 */
`include "pwsl_defs.svh"
package pwsl_pkg;
    typedef enum logic [1:0] {
        PWSL_IDLE,
        PWSL_COARSE,
        PWSL_FINE,
        PWSL_RECOVER
    } pwsl_pstate_t;
endpackage

//--- hw/pwsl_sync.sv
/*
 * two flip-flop synchroniser for one pin, with a registered previous value
 * for edge finding.
 * assumes the input is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module pwsl_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    output logic level_o,
    output logic prev_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign prev_o = prev_q;
endmodule

//--- hw/pwsl_top.sv
/*
 * pulse width serial loader: serial load of a 22-bit width setting with
 * daisy-chain output, and the digital pulse timer that uses the setting.
 * assumes all pins are asynchronous to ref_clk_i; serial clock well below 5 MHz.
 */
// Functional notes
// - enable high: shift in msb first on clock rise
// - enable fall commits setting for next trigger
// - shifting allowed during pulse, setting held
// - old register contents leave on serial out
// - serial out driven only while enable high
// - trigger rise starts pulse, retrigger ignored
// - abort ends active pulse early
// - low 6 bits fine, high 16 coarse
`timescale 1ns/1ps
`include "pwsl_defs.svh"
module pwsl_top (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic address_latch_enable_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_in_i,
    input wire logic pulse_start_input_i,
    input wire logic pulse_abort_input_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    output logic pulse_line_o,
    output logic pulse_line_inverted_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic ale_s;
    logic ale_p;
    logic sck_s;
    logic sck_p;
    logic sdi_p;
    logic trg_s;
    logic trg_p;
    logic abt_s;

    // every pin passes two stages before any logic reads it
    pwsl_sync u_ale (
        .clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(address_latch_enable_i),
        .level_o(ale_s),
        .prev_o(ale_p)
    );

    pwsl_sync u_sck (
        .clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(serial_clock_i),
        .level_o(sck_s),
        .prev_o(sck_p)
    );

    // data is taken one stage behind the clock, so the bit that stood
    // before the clock rose is the one shifted in
    pwsl_sync u_sdi (
        .clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(serial_data_in_i),
        .level_o(),
        .prev_o(sdi_p)
    );

    pwsl_sync u_trg (
        .clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pulse_start_input_i),
        .level_o(trg_s),
        .prev_o(trg_p)
    );

    // abort is a level, so its delayed copy is not needed
    pwsl_sync u_abt (
        .clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pulse_abort_input_i),
        .level_o(abt_s),
        .prev_o()
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`PWSL_SET_W-1:0] shift;
        logic [`PWSL_SET_W-1:0] active;
        logic sdo;
        logic sdo_oe;
        logic pulse;
        logic pulse_n;
        logic [`PWSL_COARSE_W-1:0] coarse_cnt;
        logic [`PWSL_FINE_W-1:0] fine_cnt;
        pwsl_pkg::pwsl_pstate_t pst;
    } pwsl_state_t;

    pwsl_state_t st_q;
    pwsl_state_t st_d;

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic sck_rise;
    logic sck_fall;
    logic ale_fall;
    logic trg_rise;

    assign sck_rise = sck_s & ~sck_p;
    assign sck_fall = ~sck_s & sck_p;
    assign ale_fall = ~ale_s & ale_p;
    assign trg_rise = trg_s & ~trg_p;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // data is sampled on the synchronised clock rise; data passes three stages,
        // one more than the clock, so the bit that stood before the rise is taken
        if (ale_s && sck_rise) begin
            st_d.shift = {st_q.shift[`PWSL_SET_W-2:0], sdi_p};
        end

        // the chain bit changes after the rising edge, so the next device
        // samples a stable bit on its own next rise
        if (ale_s) begin
            st_d.sdo_oe = 1'b1;
            if (sck_rise) begin
                st_d.sdo = st_q.shift[`PWSL_SET_W-2];
            end else if (!sck_fall && !ale_p) begin
                st_d.sdo = st_q.shift[`PWSL_SET_W-1];
            end
        end else begin
            st_d.sdo_oe = 1'b0;
            st_d.sdo = 1'b0;
        end

        // commit only on the enable fall; a running pulse keeps its count
        if (ale_fall) begin
            st_d.active = st_q.shift;
        end

        // pulse timer: coarse count first, then fine; abort cuts either
        case (st_q.pst)
            pwsl_pkg::PWSL_IDLE: begin
                if (trg_rise && !abt_s) begin
                    st_d.pulse = 1'b1;
                    st_d.pulse_n = 1'b0;
                    st_d.coarse_cnt = st_q.active[`PWSL_SET_W-1:`PWSL_FINE_W];
                    st_d.fine_cnt = st_q.active[`PWSL_FINE_W-1:0];
                    st_d.pst = pwsl_pkg::PWSL_COARSE;
                end
            end
            pwsl_pkg::PWSL_COARSE: begin
                // trigger edges here are ignored
                if (abt_s) begin
                    st_d.pst = pwsl_pkg::PWSL_RECOVER;
                end else if (st_q.coarse_cnt == `PWSL_COARSE_W'h0000) begin
                    st_d.pst = pwsl_pkg::PWSL_FINE;
                end else begin
                    st_d.coarse_cnt = st_q.coarse_cnt - `PWSL_COARSE_W'h0001;
                end
            end
            pwsl_pkg::PWSL_FINE: begin
                if (abt_s || st_q.fine_cnt == `PWSL_FINE_W'h00) begin
                    st_d.pst = pwsl_pkg::PWSL_RECOVER;
                end else begin
                    st_d.fine_cnt = st_q.fine_cnt - `PWSL_FINE_W'(`PWSL_FINE_STEP);
                end
            end
            pwsl_pkg::PWSL_RECOVER: begin
                // one cycle low before the next trigger is recognised
                st_d.pulse = 1'b0;
                st_d.pulse_n = 1'b1;
                st_d.pst = pwsl_pkg::PWSL_IDLE;
            end
            default: begin
                st_d.pst = pwsl_pkg::PWSL_IDLE;
            end
        endcase
        if (st_d.pst == pwsl_pkg::PWSL_RECOVER) begin
            st_d.pulse = 1'b0;
            st_d.pulse_n = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q.shift <= `PWSL_SET_RST;
            st_q.active <= `PWSL_SET_RST;
            st_q.sdo <= 1'b0;
            st_q.sdo_oe <= 1'b0;
            st_q.pulse <= 1'b0;
            st_q.pulse_n <= 1'b1;
            st_q.coarse_cnt <= `PWSL_COARSE_W'h0000;
            st_q.fine_cnt <= `PWSL_FINE_W'h00;
            st_q.pst <= pwsl_pkg::PWSL_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign serial_data_out_o = st_q.sdo;
    assign serial_data_out_oe_o = st_q.sdo_oe;
    assign pulse_line_o = st_q.pulse;
    assign pulse_line_inverted_o = st_q.pulse_n;
endmodule

//--- verification/pwsl_ctl_model.sv
/* serial load controller model; assumes the core clock paces its pins */
`timescale 1ns/1ps
module pwsl_ctl_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic en_o,
    output logic sclk_o,
    output logic sdi_o
);
    initial {en_o, sclk_o, sdi_o} = 3'h0;
    task automatic ld(input logic [21:0] v, output logic [21:0] old);
        en_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int i = 21; i >= 0; i--) begin
            sdi_o <= v[i];
            repeat (2) @(posedge clk_i);
            old[i] = sdo_i;
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
        en_o <= 1'b0;
        // released data line flips so a stale level is never mistaken for a hold
        sdi_o <= ~sdi_o;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic noise();
        repeat (6) begin
            sclk_o <= ~sclk_o;
            sdi_o <= ~sdi_o;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule

//--- verification/pwsl_top_sva.sv
/* pin checker of pwsl_top; assumes it is bound to the top below */
`timescale 1ns/1ps
module pwsl_top_sva (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic address_latch_enable_i,
    input wire logic serial_clock_i,
    input wire logic pulse_start_input_i,
    input wire logic pulse_abort_input_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o,
    input wire logic pulse_line_o,
    input wire logic pulse_line_inverted_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_idle;
        !pulse_line_o [*4];
    endsequence
    sequence s_pulse_start_input;
        $rose(pulse_start_input_i) && !pulse_abort_input_i;
    endsequence
    a_oe_on_rise: assert property ($rose(address_latch_enable_i) |-> ##[1:4] serial_data_out_oe_o)
        else $error("chain output not enabled");
    a_oe_off_fall: assert property ($fell(address_latch_enable_i) |-> ##[1:4] !serial_data_out_oe_o)
        else $error("chain output not released");
    a_oe_only_enabled: assert property ((!address_latch_enable_i) [*5] |-> !serial_data_out_oe_o)
        else $error("chain output driven while disabled");
    a_sdo_quiet: assert property (!serial_data_out_oe_o |-> !serial_data_out_o)
        else $error("chain data not quiet");
    a_sdo_no_clock: assert property ((address_latch_enable_i && !serial_clock_i) [*5] |-> $stable(serial_data_out_o))
        else $error("chain data moved without clock");
    a_pulse_start: assert property (s_idle ##1 s_pulse_start_input |-> ##[1:6] pulse_line_o)
        else $error("trigger did not start pulse");
    a_pulse_min: assert property ($rose(pulse_line_o) && !pulse_abort_input_i |-> pulse_line_o [*2])
        else $error("pulse shorter than two cycles");
    a_abort_ends: assert property (pulse_abort_input_i [*5] |-> !pulse_line_o)
        else $error("abort did not end pulse");
    a_pulse_pair: assert property (pulse_line_inverted_o == !pulse_line_o)
        else $error("pulse outputs not complementary");
endmodule
bind pwsl_top pwsl_top_sva chk (.ref_clk_i, .arst_n_i, .address_latch_enable_i, .serial_clock_i,
    .pulse_start_input_i, .pulse_abort_input_i, .serial_data_out_o, .serial_data_out_oe_o, .pulse_line_o,
    .pulse_line_inverted_o);

//--- verification/pwsl_top_tb.sv
/* bench of pwsl_top; assumes the controller model and the bound checker */
`timescale 1ns/1ps
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        num_errors++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, a, e); \
    end \
end
module pwsl_top_tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic pulse_start_input_i = 1'b0;
    logic pulse_abort_input_i = 1'b0;
    logic address_latch_enable_i, serial_clock_i, serial_data_in_i;
    logic serial_data_out_o, serial_data_out_oe_o, pulse_line_o, pulse_line_inverted_o;
    logic [21:0] cur = 22'h000000;
    logic [21:0] lng = 22'h004B14;
    logic [21:0] got, sh;
    logic [31:0] seed = 32'h5D6F;
    int num_errors = 0;
    int check_count = 0;
    int w;
    always #25 ref_clk_i = ~ref_clk_i;
    pwsl_ctl_model ctl (.clk_i(ref_clk_i), .sdo_i(serial_data_out_o), .en_o(address_latch_enable_i),
        .sclk_o(serial_clock_i), .sdi_o(serial_data_in_i));
    pwsl_top uut (.ref_clk_i, .arst_n_i, .address_latch_enable_i, .serial_clock_i, .serial_data_in_i,
        .pulse_start_input_i, .pulse_abort_input_i, .serial_data_out_o, .serial_data_out_oe_o, .pulse_line_o,
        .pulse_line_inverted_o);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // width is a digital stand-in, so one cycle of slack either way
    function automatic logic ok_w(input int n, input logic [21:0] v);
        return n >= int'(v[21:6]) + int'(v[5:0]) + 1 && n <= int'(v[21:6]) + int'(v[5:0]) + 3;
    endfunction
    task automatic load(input logic [21:0] v);
        ctl.ld(v, got);
        `CHK(got, cur)
        cur = v;
    endtask
    task automatic fire(output int n);
        n = 0;
        pulse_start_input_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        pulse_start_input_i <= 1'b0;
        for (int i = 0; i < 8 && pulse_line_o !== 1'b1; i++) @(posedge ref_clk_i);
        while (pulse_line_o === 1'b1 && n < 9000) begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        `CHK({serial_data_out_oe_o, pulse_line_o, pulse_line_inverted_o}, 3'b001)
        for (int k = 0; k < 5; k++) begin
            seed = xs(seed);
            sh = (k == 0) ? 22'h000000 : ((k == 1) ? 22'h00003F : {10'h000, seed[11:0]});
            load(seed[31:10]);
            load(sh);
            fire(w);
            `CHK(ok_w(w, sh), 1'b1)
            $display("test random_load %0d done", k);
        end
        ctl.noise();
        fire(w);
        `CHK(ok_w(w, sh), 1'b1)
        load(lng);
        $display("test idle_clock done");
        fork
            fire(w);
            begin
                repeat (10) @(posedge ref_clk_i);
                load(sh);
                pulse_start_input_i <= 1'b1;
                repeat (4) @(posedge ref_clk_i);
                pulse_start_input_i <= 1'b0;
            end
        join
        `CHK(ok_w(w, lng), 1'b1)
        repeat (4) @(posedge ref_clk_i);
        fire(w);
        `CHK(ok_w(w, sh), 1'b1)
        $display("test load_during_pulse done");
        load(lng);
        fork
            fire(w);
            begin
                repeat (30) @(posedge ref_clk_i);
                pulse_abort_input_i <= 1'b1;
            end
        join
        `CHK(w < 40, 1'b1)
        // abort stays up long enough for the level check to see it
        repeat (4) @(posedge ref_clk_i);
        `CHK(pulse_line_o, 1'b0)
        pulse_abort_input_i <= 1'b0;
        $display("test abort done");
        repeat (6) @(posedge ref_clk_i);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        final_report();
    end
endmodule
